// [mmc_pkg.sv]
// Purpose: Shared constants, types and helpers for the measurement mode controller
// Assumes: 20 MHz system clock, registers reached over the three-wire serial port
// Notes: One-time memory bit layout and a few timings are fixed here
package mmc_pkg;
	localparam int SYS_CLK_HZ = 20000000;
	localparam int OTP_BITS = 188;
	localparam int TRR_W = 20;
	localparam int CAR_W = 110;
	localparam int SN_W = 24;
	localparam int TREF_W = 11;
	localparam int TRR_LSB = 0;
	localparam int CAR_LSB = 20;
	localparam int SN_LSB = 130;
	localparam int TREF_LSB = 154;
	localparam int CFG_W = 17;
	localparam int CRG_W = 28;
	localparam int MSR_W = 18;
	localparam int THR_W = 17;
	localparam int TST_W = 20;
	localparam int RES_W = 16;
	localparam int PD_W = 7;
	localparam int SEQ_LSB = 24;
	localparam int THR_CHAN_BIT = 16;
	localparam int MSR_CHAN_BIT = 17;
	localparam int MSR_OVF_BIT = 16;
	localparam logic [3:0] ADDR_OPM = 4'h0;
	localparam logic [3:0] ADDR_CRA = 4'h1;
	localparam logic [3:0] ADDR_CRB = 4'h2;
	localparam logic [3:0] ADDR_CRG = 4'h3;
	localparam logic [3:0] ADDR_MSR = 4'h4;
	localparam logic [3:0] ADDR_ZZR = 4'h5;
	localparam logic [3:0] ADDR_CAR = 4'h6;
	localparam logic [3:0] ADDR_TRR = 4'h7;
	localparam logic [3:0] ADDR_THR = 4'h8;
	localparam logic [3:0] ADDR_TST = 4'h9;
	localparam logic [CRG_W-1:0] CRG_RESET = 28'h1C00004;
	localparam logic [THR_W-1:0] THR_RESET = 17'h04000;
	localparam logic [3:0] TREF_TOP = 4'h5;
	localparam logic [PD_W-1:0] PD_SLEEP = 7'h3F;
	localparam logic [PD_W-1:0] PD_NONE = 7'h00;
	localparam logic [4:0] INT_SLOW = 5'h10;
	localparam longint WAKE_PERIOD_MS = 1000;
	localparam longint WAKE_CYCLES = (SYS_CLK_HZ * WAKE_PERIOD_MS) / 1000;
	localparam longint SETTLE_US = 100;
	localparam longint SETTLE_CYCLES = (SYS_CLK_HZ * SETTLE_US + 999999) / 1000000;

	typedef enum logic [3:0] {
		power_on_load_mode = 4'h0,
		single_measure_mode = 4'h1,
		dual_measure_mode = 4'h2,
		wake_up_mode = 4'h3,
		alarm_mode = 4'h4,
		factory_program_mode = 4'h5,
		power_down_mode = 4'h6,
		internal_clock_measure_mode = 4'h7
	} mode_e;

	typedef enum logic [2:0] {
		S_LOAD = 3'h0,
		S_IDLE = 3'h1,
		S_RUN = 3'h3,
		S_WAIT = 3'h2,
		S_SLEEP = 3'h6,
		S_WAKE = 3'h7,
		S_WMEAS = 3'h5
	} seq_e;

	typedef struct packed {
		logic done;
		logic overflow;
		logic [RES_W-1:0] value;
	} conv_res_s;

	typedef struct packed {
		logic rd_start;
		logic wr_commit;
		logic [3:0] addr;
		logic [OTP_BITS-1:0] data;
	} ser_cmd_s;

	function automatic logic [7:0] reg_width(input logic [3:0] a);
		case (a)
			ADDR_OPM: reg_width = 8'h04;
			ADDR_CRA, ADDR_CRB, ADDR_THR: reg_width = 8'h11;
			ADDR_CRG: reg_width = 8'h1C;
			ADDR_MSR: reg_width = 8'h12;
			ADDR_ZZR: reg_width = 8'hBC;
			ADDR_CAR: reg_width = 8'h6E;
			ADDR_TRR, ADDR_TST: reg_width = 8'h14;
			default: reg_width = 8'h01;
		endcase
	endfunction

	// Positive threshold: result above it; negative threshold: result below it
	function automatic logic exceeds(input logic [RES_W-1:0] res, input logic [RES_W-1:0] threshold_register);
		if (threshold_register[RES_W-1])
			exceeds = $signed(res) < $signed(threshold_register);
		else
			exceeds = $signed(res) > $signed(threshold_register);
	endfunction
endpackage

// [otp_memory.sv]
// Purpose: One-time programmable bit store with registered read
// Assumes: Contents are fixed at build time through the INIT parameter
// Notes: Programming is a factory step and is not modelled
`timescale 1ns/1ns
module otp_memory #(
	parameter int DEPTH = mmc_pkg::OTP_BITS,
	parameter logic [DEPTH-1:0] INIT = '0
) (
	input wire logic clk_sys, // System clock
	input wire logic ce, // Clock enable
	input wire logic [7:0] rd_addr, // Bit index
	output logic rd_bit // Registered read data
);
	import mmc_pkg::*;

	always_ff @(posedge clk_sys)
	begin
		if (ce)
			rd_bit <= (rd_addr < DEPTH) ? INIT[rd_addr] : 1'b0;
	end
endmodule

// [serial_port.sv]
// Purpose: Three-wire serial frame engine: r/w bit, 4-bit address, MSB-first data
// Assumes: Pins already synchronous to clk_sys
// Notes: Writes are committed only when a frame closes with the exact bit count
`timescale 1ns/1ns
module serial_port (
	input wire logic clk_sys, // System clock
	input wire logic sys_rst, // Synchronous reset
	input wire logic ce, // Clock enable
	input wire logic ser_sel, // Frame select, high in a frame
	input wire logic ser_clk, // Serial clock, data taken on rise
	input wire logic ser_din, // Serial data in
	output logic ser_dout, // Serial data out
	output logic ser_dout_oe, // Data out enable
	input wire logic [mmc_pkg::OTP_BITS-1:0] rd_data, // Read data of addressed register
	output mmc_pkg::ser_cmd_s cmd // Decoded request
);
	import mmc_pkg::*;

	logic clk_q_reg;
	logic sel_q_reg;
	logic rw_reg;
	logic [7:0] cnt_reg;
	logic [3:0] addr_reg;
	logic [OTP_BITS-1:0] in_reg;
	logic [OTP_BITS-1:0] out_reg;
	wire rise = ser_sel & ser_clk & ~clk_q_reg;
	wire frame_end = sel_q_reg & ~ser_sel;
	wire [7:0] width = reg_width(addr_reg);
	wire [7:0] full_cnt = 8'h05 + width;
	wire addr_done = rise && (cnt_reg == 8'h04);

	assign ser_dout = out_reg[OTP_BITS-1];
	assign ser_dout_oe = ser_sel & rw_reg & (cnt_reg >= 8'h05);
	assign cmd.addr = addr_reg;
	assign cmd.data = in_reg;

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			clk_q_reg <= 1'b0;
			sel_q_reg <= 1'b0;
			rw_reg <= 1'b0;
			cnt_reg <= 8'h00;
			addr_reg <= 4'h0;
			in_reg <= '0;
			out_reg <= '0;
			cmd.rd_start <= 1'b0;
			cmd.wr_commit <= 1'b0;
		end
		else if (ce)
		begin
			clk_q_reg <= ser_clk;
			sel_q_reg <= ser_sel;
			cmd.rd_start <= addr_done & rw_reg;
			// A short or aborted frame never reaches the commit
			cmd.wr_commit <= frame_end & ~rw_reg & (cnt_reg == full_cnt);
			if (!ser_sel)
				cnt_reg <= 8'h00;
			else if (rise && cnt_reg != 8'hFF)
				cnt_reg <= cnt_reg + 8'h01;
			if (rise)
			begin
				if (cnt_reg == 8'h00)
					rw_reg <= ser_din;
				else if (cnt_reg < 8'h05)
					addr_reg <= {addr_reg[2:0], ser_din};
				else
				begin
					in_reg <= {in_reg[OTP_BITS-2:0], ser_din};
					out_reg <= {out_reg[OTP_BITS-2:0], 1'b0};
				end
			end
			if (cmd.rd_start)
				out_reg <= rd_data << (OTP_BITS - int'(width));
		end
	end
endmodule

// [measurement_mode_controller.sv]
// Purpose: Mode register, power-on load and measurement sequencing of the front end
// Assumes: Converter core reports results through conv_res; pins synchronous to clk_sys
// Notes: sys_rst stands for the power-on reset; the load runs right after it
// Summary of operation
// - Four-bit mode register; codes 0-7 named modes, top bit set means test.
// - Supply rise loads calibration from one-time memory, then default mode.
// - Power-on load mode fills registers from one-time memory after reset.
// - Single mode measures channel A continuously; ready pin low on new result.
// - Dual mode alternates A and B; result bit 17 marks channel B.
// - Dual mode run length per channel comes from the sequence length field.
// - Dual mode disables averaging; each channel keeps its own rate.
// - Sampling rate follows the active channel's oversampling, chop and averaging.
// - Wake-up mode: internal clock, power up ground and reference, then measure A.
// - After wake-up measurement store result, sleep, pulse interrupt on threshold.
// - Serial port works during sleep; host restarts clock before leaving.
// - Alarm mode measures A, pin high, one-cycle low pulse on threshold exceed.
// - Power down stops acquisition; analog blocks follow their power-down bits.
// - Internal-clock mode is single mode on internal clock, sixteen times slower.
// - Calibration, trimming and test registers writable only in test modes.
// - Saturation from an open shunt terminal sets the result overflow flag.
// - Temperature sensor measurable any time with gain 6 via channel config.
// - Temperature reference rebuilt as 0101, stored 11 bits, trailing zero.
// - A 24-bit serial number is held in one-time memory with calibration.
// - Gain calibration coefficients from one-time memory drive the converter.
// - After power-on load: wake-up mode without external clock, else single mode.
`timescale 1ns/1ns
module measurement_mode_controller #(
	parameter longint WAKE_PERIOD = mmc_pkg::WAKE_CYCLES,
	parameter longint SETTLE_TIME = mmc_pkg::SETTLE_CYCLES,
	parameter logic [mmc_pkg::CFG_W-1:0] CRA_RESET = '0,
	parameter logic [mmc_pkg::CFG_W-1:0] CRB_RESET = '0,
	parameter logic [mmc_pkg::TST_W-1:0] TST_RESET = '0,
	parameter logic [mmc_pkg::OTP_BITS-1:0] OTP_INIT = '0 // Arbitrary contents
) (
	input wire logic clk_sys, // System clock, 20 MHz
	input wire logic sys_rst, // Power-on reset, synchronous, active high
	input wire logic ce, // Clock enable, freezes all state when low
	input wire logic ext_clk_present, // External clock detected
	input wire logic ser_sel, // Serial frame select
	input wire logic ser_clk, // Serial clock
	input wire logic ser_din, // Serial data in
	output logic ser_dout, // Serial data out
	output logic ser_dout_oe, // Serial data out enable
	input mmc_pkg::conv_res_s conv_res, // Converter result
	output logic conv_start, // Start one measurement
	output logic [mmc_pkg::CFG_W-1:0] conv_cfg, // Active channel configuration
	output logic [mmc_pkg::CRG_W-1:0] conv_gen_cfg, // General configuration
	output logic conv_avg_en, // Internal averaging allowed
	output logic conv_pace, // Converter step enable
	output logic clk_int_sel, // Run from internal oscillator
	output logic [mmc_pkg::PD_W-1:0] analog_pd, // Analog block power-down, 1 = off
	output logic [mmc_pkg::CAR_W-1:0] cal_coeffs, // Calibration register
	output logic [mmc_pkg::TRR_W-1:0] trim_value, // Trimming register
	output logic [mmc_pkg::TST_W-1:0] test_cfg, // Test configuration register
	output logic [mmc_pkg::SN_W-1:0] serial_number, // Part serial number
	output logic [mmc_pkg::RES_W-1:0] temp_ref_value, // 23 degree reference value
	output logic [3:0] operating_mode, // Current mode register
	output logic ready_interrupt_n // Ready or interrupt, active low
);
	import mmc_pkg::*;

	logic [3:0] operating_mode_select_reg;
	logic [CFG_W-1:0] channel_a_config_reg;
	logic [CFG_W-1:0] channel_b_config_reg;
	logic [CRG_W-1:0] general_config_reg;
	logic [THR_W-1:0] threshold_register_reg;
	logic [MSR_W-1:0] result_register_reg;
	logic [OTP_BITS-1:0] one_time_memory_register_reg;
	logic [CAR_W-1:0] calibration_register_reg;
	logic [TRR_W-1:0] trimming_register_reg;
	logic [TST_W-1:0] test_cfg_reg;
	seq_e state_reg;
	seq_e state_next;
	logic [8:0] load_cnt_reg;
	logic [3:0] seq_cnt_reg;
	logic chan_reg;
	logic [63:0] timer_reg;
	logic [3:0] pace_cnt_reg;
	logic ready_n_reg;
	logic start_reg;
	logic otp_bit;
	logic [OTP_BITS-1:0] rd_data;
	ser_cmd_s cmd;

	otp_memory #(
		.DEPTH(OTP_BITS),
		.INIT(OTP_INIT)
	) u_otp (
		.clk_sys(clk_sys),
		.ce(ce),
		.rd_addr(load_cnt_reg[7:0]),
		.rd_bit(otp_bit)
	);

	serial_port u_ser (
		.clk_sys(clk_sys),
		.sys_rst(sys_rst),
		.ce(ce),
		.ser_sel(ser_sel),
		.ser_clk(ser_clk),
		.ser_din(ser_din),
		.ser_dout(ser_dout),
		.ser_dout_oe(ser_dout_oe),
		.rd_data(rd_data),
		.cmd(cmd)
	);

	// Mode decode
	wire test_mode = operating_mode_select_reg[3];
	wire m_single = operating_mode_select_reg == single_measure_mode;
	wire m_dual = operating_mode_select_reg == dual_measure_mode;
	wire m_wake = operating_mode_select_reg == wake_up_mode;
	wire m_alarm = operating_mode_select_reg == alarm_mode;
	wire m_pd = operating_mode_select_reg == power_down_mode;
	wire m_int = operating_mode_select_reg == internal_clock_measure_mode;
	wire m_meas = m_single | m_dual | m_alarm | m_int;
	wire load_last = load_cnt_reg == 9'(OTP_BITS);
	wire [3:0] seq_len_m1 = general_config_reg[SEQ_LSB +: 4] - 4'h1;
	wire seq_wrap = seq_cnt_reg == seq_len_m1;
	wire [RES_W-1:0] thr_val = threshold_register_reg[RES_W-1:0];
	wire hit = exceeds(conv_res.value, thr_val);
	wire result_in = conv_res.done & ((state_reg == S_WAIT) | (state_reg == S_WMEAS));
	wire mode_wr = cmd.wr_commit & (cmd.addr == ADDR_OPM);
	// Test-only registers silently ignore writes outside test modes
	wire cal_wr_ok = cmd.wr_commit & test_mode;
	wire cfg_wr = cmd.wr_commit & (state_reg != S_LOAD);
	wire msr_read = cmd.rd_start & (cmd.addr == ADDR_MSR);
	wire wake_due = timer_reg >= 64'(WAKE_PERIOD - 1);
	wire settle_due = timer_reg >= 64'(SETTLE_TIME - 1);
	wire chan_now = m_dual & chan_reg;
	wire [MSR_W-1:0] result_word = {chan_now, conv_res.overflow, conv_res.value};
	// Word after this cycle's shift, so the final copy includes the last bit read
	wire [OTP_BITS-1:0] otp_word = {otp_bit, one_time_memory_register_reg[OTP_BITS-1:1]};

	// Reads: reserved addresses answer zero
	always_comb
	begin
		rd_data = '0;
		case (cmd.addr)
			ADDR_OPM: rd_data[3:0] = operating_mode_select_reg;
			ADDR_CRA: rd_data[CFG_W-1:0] = channel_a_config_reg;
			ADDR_CRB: rd_data[CFG_W-1:0] = channel_b_config_reg;
			ADDR_CRG: rd_data[CRG_W-1:0] = general_config_reg;
			ADDR_MSR: rd_data[MSR_W-1:0] = result_register_reg;
			ADDR_ZZR: rd_data = one_time_memory_register_reg;
			ADDR_CAR: rd_data[CAR_W-1:0] = calibration_register_reg;
			ADDR_TRR: rd_data[TRR_W-1:0] = trimming_register_reg;
			ADDR_THR: rd_data[THR_W-1:0] = threshold_register_reg;
			ADDR_TST: rd_data[TST_W-1:0] = test_mode ? test_cfg_reg : '0;
			default: rd_data = '0;
		endcase
	end

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			S_LOAD:
				if (load_last)
					state_next = S_IDLE;
			S_IDLE:
				if (m_meas)
					state_next = S_RUN;
				else if (m_wake)
					state_next = S_SLEEP;
			S_RUN:
				if (conv_pace)
					state_next = S_WAIT;
			S_WAIT:
				if (conv_res.done)
					state_next = S_RUN;
			S_SLEEP:
				if (wake_due)
					state_next = S_WAKE;
			S_WAKE:
				if (settle_due)
					state_next = S_WMEAS;
			S_WMEAS:
				if (conv_res.done)
					state_next = S_SLEEP;
			default:
				state_next = S_IDLE;
		endcase
		// Any mode change restarts the sequencer from idle
		if (mode_wr && state_reg != S_LOAD)
			state_next = S_IDLE;
		// No acquisition in power down, factory or test modes
		if (!m_meas && !m_wake && state_reg != S_LOAD)
			state_next = S_IDLE;
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			state_reg <= S_LOAD;
			operating_mode_select_reg <= power_on_load_mode;
			load_cnt_reg <= 9'h000;
			one_time_memory_register_reg <= '0;
		end
		else if (ce)
		begin
			state_reg <= state_next;
			if (state_reg == S_LOAD && !load_last)
				load_cnt_reg <= load_cnt_reg + 9'h001;
			// Read data lags the address by one cycle, so bit 0 lands at the bottom
			if (state_reg == S_LOAD && load_cnt_reg != 9'h000)
				one_time_memory_register_reg <= otp_word;
			if (state_reg == S_LOAD && load_last)
				operating_mode_select_reg <= ext_clk_present ? single_measure_mode : wake_up_mode;
			else if (mode_wr && state_reg != S_LOAD)
				operating_mode_select_reg <= cmd.data[3:0];
		end
	end

	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			channel_a_config_reg <= CRA_RESET;
			channel_b_config_reg <= CRB_RESET;
			general_config_reg <= CRG_RESET;
			threshold_register_reg <= THR_RESET;
			calibration_register_reg <= '0;
			trimming_register_reg <= '0;
			test_cfg_reg <= TST_RESET;
		end
		else if (ce)
		begin
			if (state_reg == S_LOAD && load_last)
			begin
				calibration_register_reg <= otp_word[CAR_LSB +: CAR_W];
				trimming_register_reg <= otp_word[TRR_LSB +: TRR_W];
			end
			if (cfg_wr && cmd.addr == ADDR_CRA)
				channel_a_config_reg <= cmd.data[CFG_W-1:0];
			if (cfg_wr && cmd.addr == ADDR_CRB)
				channel_b_config_reg <= cmd.data[CFG_W-1:0];
			if (cfg_wr && cmd.addr == ADDR_CRG)
				general_config_reg <= cmd.data[CRG_W-1:0];
			if (cfg_wr && cmd.addr == ADDR_THR)
				threshold_register_reg <= cmd.data[THR_W-1:0];
			if (cal_wr_ok && cmd.addr == ADDR_CAR)
				calibration_register_reg <= cmd.data[CAR_W-1:0];
			if (cal_wr_ok && cmd.addr == ADDR_TRR)
				trimming_register_reg <= cmd.data[TRR_W-1:0];
			if (cal_wr_ok && cmd.addr == ADDR_TST)
				test_cfg_reg <= cmd.data[TST_W-1:0];
		end
	end

	// Result capture, dual-channel alternation and timers
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
		begin
			result_register_reg <= '0;
			seq_cnt_reg <= 4'h0;
			chan_reg <= 1'b0;
			timer_reg <= 64'h0;
			pace_cnt_reg <= 4'h0;
			start_reg <= 1'b0;
		end
		else if (ce)
		begin
			start_reg <= ((state_reg == S_RUN) & conv_pace) | ((state_reg == S_WAKE) & settle_due);
			pace_cnt_reg <= pace_cnt_reg + 4'h1;
			if (result_in)
				result_register_reg <= result_word;
			if (state_reg == S_IDLE)
			begin
				seq_cnt_reg <= 4'h0;
				chan_reg <= 1'b0;
			end
			else if (result_in && m_dual)
			begin
				seq_cnt_reg <= seq_wrap ? 4'h0 : seq_cnt_reg + 4'h1;
				if (seq_wrap)
					chan_reg <= ~chan_reg;
			end
			if (state_reg != state_next)
				timer_reg <= 64'h0;
			else if (state_reg == S_SLEEP || state_reg == S_WAKE)
				timer_reg <= timer_reg + 64'h1;
		end
	end

	// Ready stays low after a result until the host reads it; alarm and wake pulse one cycle
	always_ff @(posedge clk_sys)
	begin
		if (sys_rst)
			ready_n_reg <= 1'b1;
		else if (ce)
		begin
			if (state_reg == S_LOAD)
				ready_n_reg <= load_cnt_reg[0] | load_last; // Load progress, idle high after
			else if (result_in && (m_single || m_int || m_dual))
				ready_n_reg <= 1'b0;
			else if (result_in && (m_alarm || state_reg == S_WMEAS))
				ready_n_reg <= ~hit;
			else if (msr_read || m_alarm || m_wake || !m_meas)
				ready_n_reg <= 1'b1;
		end
	end

	// Pace divides the converter step rate in internal-clock measure mode only, not in wake-up mode
	assign conv_pace = m_int ? (pace_cnt_reg == 4'(INT_SLOW - 5'h01)) : 1'b1;
	assign conv_start = start_reg;
	// Wake-up and alarm always use channel A; rate figures come from the active set
	assign conv_cfg = chan_now ? channel_b_config_reg : channel_a_config_reg;
	assign conv_gen_cfg = general_config_reg;
	// Shared filter state cannot follow channel switches, so averaging is off in dual
	assign conv_avg_en = ~m_dual;
	assign clk_int_sel = (state_reg == S_LOAD) | m_wake | m_int;
	assign analog_pd = m_pd ? general_config_reg[PD_W-1:0] :
		(state_reg == S_SLEEP) ? PD_SLEEP : PD_NONE;
	assign cal_coeffs = calibration_register_reg;
	assign trim_value = trimming_register_reg;
	assign test_cfg = test_cfg_reg;
	assign serial_number = one_time_memory_register_reg[SN_LSB +: SN_W];
	assign temp_ref_value = {TREF_TOP, one_time_memory_register_reg[TREF_LSB +: TREF_W], 1'b0};
	assign operating_mode = operating_mode_select_reg;
	assign ready_interrupt_n = ready_n_reg;
endmodule

// [mmc_monitor.sv]
// Purpose: Port assertions for measurement_mode_controller
// Assumes: One clock domain, synchronous active high reset
// Notes: Bound from the testbench file
`timescale 1ns/1ns
module mmc_monitor (
	input wire logic clk_sys, // Clock
	input wire logic sys_rst, // Reset
	input wire logic ser_sel, // Frame select
	input wire mmc_pkg::conv_res_s conv_res, // Converter result
	input wire logic conv_start, // Start pulse
	input wire logic [27:0] conv_gen_cfg, // General config
	input wire logic conv_avg_en, // Averaging enable
	input wire logic conv_pace, // Step enable
	input wire logic clk_int_sel, // Internal clock select
	input wire logic [6:0] analog_pd, // Block power-down
	input wire logic [109:0] cal_coeffs, // Calibration
	input wire logic [19:0] trim_value, // Trimming
	input wire logic [15:0] temp_ref_value, // Temperature reference
	input wire logic [3:0] operating_mode, // Mode
	input wire logic ready_interrupt_n // Ready, active low
);
	import mmc_pkg::*;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (sys_rst);
	sequence s_hold;
		(operating_mode == 4'h0) [*8];
	endsequence
	sequence s_pulse;
		!ready_interrupt_n ##1 ready_interrupt_n;
	endsequence
	property p_load_hold; $fell(sys_rst) |-> s_hold; endproperty
	a_load_hold: assert property (p_load_hold) else $error("load left early");
	property p_ready; operating_mode inside {4'h1, 4'h2, 4'h7} && conv_res.done
		|=> !ready_interrupt_n; endproperty
	a_ready: assert property (p_ready) else $error("no ready after result");
	property p_irq_pulse; operating_mode inside {4'h3, 4'h4} && $fell(ready_interrupt_n)
		|-> s_pulse; endproperty
	a_irq_pulse: assert property (p_irq_pulse) else $error("pulse not one cycle");
	property p_alarm_cause; operating_mode == 4'h4 && $fell(ready_interrupt_n)
		|-> $past(conv_res.done); endproperty
	a_alarm_cause: assert property (p_alarm_cause) else $error("alarm without result");
	property p_dual_avg; operating_mode == 4'h2 && $stable(operating_mode)
		|-> !conv_avg_en; endproperty
	a_dual_avg: assert property (p_dual_avg) else $error("averaging in dual");
	property p_int_pace; operating_mode == 4'h7 && $stable(operating_mode) && conv_pace
		|=> (!conv_pace) [*8]; endproperty
	a_int_pace: assert property (p_int_pace) else $error("pace too fast");
	property p_int_clk; operating_mode inside {4'h3, 4'h7} && $stable(operating_mode)
		|-> clk_int_sel; endproperty
	a_int_clk: assert property (p_int_clk) else $error("internal clock off");
	property p_pd; operating_mode == 4'h6 && $stable(operating_mode)
		|-> !conv_start && analog_pd == conv_gen_cfg[6:0]; endproperty
	a_pd: assert property (p_pd) else $error("power down wrong");
	property p_cal_lock; $changed(cal_coeffs) || $changed(trim_value)
		|-> $past(operating_mode[3]) || $past(operating_mode) == 4'h0; endproperty
	a_cal_lock: assert property (p_cal_lock) else $error("calibration written");
	property p_mode_commit; $changed(operating_mode) |-> !ser_sel && !$past(ser_sel);
	endproperty
	a_mode_commit: assert property (p_mode_commit) else $error("mode changed in frame");
	property p_tref; operating_mode != 4'h0
		|-> temp_ref_value[15:12] == 4'h5 && !temp_ref_value[0]; endproperty
	a_tref: assert property (p_tref) else $error("reference framing");
endmodule

// [mmc_host.sv]
// Purpose: Host controller model on the three-wire serial port
// Assumes: Frame is r/w bit, address, data, all MSB first
// Notes: Read data sampled just before each data rise
`timescale 1ns/1ns
module mmc_host (
	input wire logic clk_sys, // System clock
	output logic ser_sel, // Frame select
	output logic ser_clk, // Serial clock
	output logic ser_din, // Serial data out of host
	input wire logic ser_dout // Serial data from device
);
	initial
	begin
		ser_sel = 1'b0;
		ser_clk = 1'b0;
		ser_din = 1'b0;
	end
	// Idle data keeps moving so no stale bit can pass for a real one
	always @(negedge clk_sys)
		if (!ser_sel)
			ser_din <= ~ser_din;
	task automatic xfer(input logic rw, input logic [3:0] a, input int w,
		input logic [187:0] d, output logic [187:0] q);
		q = '0;
		@(posedge clk_sys);
		#1;
		ser_sel = 1'b1;
		for (int i = 0; i < w + 5; i++)
		begin
			ser_clk = 1'b0;
			ser_din = (i == 0) ? rw : (i < 5) ? a[4 - i] : d[w + 4 - i];
			repeat (2) @(posedge clk_sys);
			#1;
			if (i >= 5)
				q = {q[186:0], ser_dout};
			ser_clk = 1'b1;
			@(posedge clk_sys);
			#1;
		end
		ser_clk = 1'b0;
		ser_sel = 1'b0;
		repeat (3) @(posedge clk_sys);
		#1;
	endtask
endmodule

// [measurement_mode_controller_tb.sv]
// Purpose: Self-checking bench for measurement_mode_controller
// Assumes: Host model drives the serial port, the bench plays the converter
// Notes: Wake period and settle time cut to 50 and 5 cycles
`timescale 1ns/1ns
module measurement_mode_controller_tb;
	import mmc_pkg::*;
	localparam logic [187:0] OTP = 188'({6{32'hA5C31E97}});
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic pend = 1'b0;
	logic ce = 1'b1;
	logic ext_clk_present = 1'b1;
	conv_res_s conv_res = '0;
	logic ser_sel, ser_clk, ser_din, ser_dout, conv_start, conv_avg_en, conv_pace, clk_int_sel;
	logic ready_interrupt_n;
	logic [27:0] conv_gen_cfg;
	logic [6:0] analog_pd;
	logic [109:0] cal_coeffs;
	logic [19:0] trim_value;
	logic [23:0] serial_number;
	logic [15:0] temp_ref_value;
	logic [3:0] operating_mode;
	logic [187:0] q;
	logic [31:0] lfsr = 32'hC696;
	logic [15:0] tv [4] = '{16'h2000, 16'h1000, 16'hE000, 16'hF000};
	logic [17:0] exp_q[$];
	int fail_count = 0;
	int n_compared = 0;
	measurement_mode_controller #(.WAKE_PERIOD(50), .SETTLE_TIME(5), .OTP_INIT(OTP)) dut (
		.clk_sys, .sys_rst, .ce, .ext_clk_present, .ser_sel, .ser_clk,
		.ser_din, .ser_dout, .ser_dout_oe(), .conv_res, .conv_start, .conv_cfg(),
		.conv_gen_cfg, .conv_avg_en, .conv_pace, .clk_int_sel, .analog_pd, .cal_coeffs,
		.trim_value, .test_cfg(), .serial_number, .temp_ref_value, .operating_mode,
		.ready_interrupt_n);
	mmc_host host (.clk_sys, .ser_sel, .ser_clk, .ser_din, .ser_dout);
	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		if (conv_start)
			pend <= 1'b1;
	function automatic logic [31:0] nxt(input logic [31:0] s);
		nxt = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic pin(input logic [15:0] t, input logic [15:0] v);
		int a;
		int b;
		a = $signed(v);
		b = $signed(t);
		pin = t[15] ? !(a < b) : !(a > b);
	endfunction
	task automatic chk(input string nm, input logic [187:0] seen, input logic [187:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic end_sim;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic wr(input logic [3:0] a, input int w, input logic [187:0] d);
		host.xfer(1'b0, a, w, d, q);
		// A new mode restarts the sequence, so older starts no longer count
		if (a == 4'h0)
			pend = 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input int w);
		host.xfer(1'b1, a, w, '0, q);
	endtask
	task automatic conv(input logic ovf, input logic [15:0] v);
		int k;
		k = 0;
		repeat (4) @(posedge clk_sys);
		#1;
		while (pend !== 1'b1 && k < 400)
		begin
			@(posedge clk_sys);
			#1;
			k++;
		end
		chk("start", pend, 1);
		pend = 1'b0;
		conv_res = '{1'b1, ovf, v};
		@(posedge clk_sys);
		#1;
		conv_res.done = 1'b0;
	endtask
	task automatic meas(input logic ch, input logic [15:0] v);
		lfsr = nxt(lfsr);
		conv(lfsr[0], v);
		exp_q.push_back({ch, lfsr[0], v});
		chk("ready", ready_interrupt_n, 0);
		rd(4'h4, 18);
		chk("result", q[17:0], exp_q.pop_front());
		chk("ready_clear", ready_interrupt_n, 1);
	endtask
	initial
	begin
		repeat (5) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		repeat (200) @(posedge clk_sys);
		#1;
		chk("mode", operating_mode, 1);
		chk("cal", cal_coeffs, OTP[129:20]);
		chk("trim", trim_value, OTP[19:0]);
		chk("serial", serial_number, OTP[153:130]);
		chk("tref", temp_ref_value, {4'h5, OTP[164:154], 1'b0});
		chk("general", conv_gen_cfg, 28'h1C00004);
		for (int i = 0; i < 3; i++)
		begin
			lfsr = nxt(lfsr);
			meas(1'b0, lfsr[31:16]);
		end
		wr(4'h3, 28, 28'h2C00004);
		wr(4'h0, 4, 2);
		for (int i = 0; i < 6; i++)
		begin
			lfsr = nxt(lfsr);
			meas(1'(i / 2 % 2), lfsr[31:16]);
		end
		wr(4'h8, 17, 17'h01000);
		wr(4'h0, 4, 4);
		for (int i = 0; i < 4; i++)
		begin
			if (i == 2)
				wr(4'h8, 17, 17'h0F000);
			conv(1'b0, tv[i]);
			chk("alarm", ready_interrupt_n, pin(i < 2 ? 16'h1000 : 16'hF000, tv[i]));
		end
		wr(4'h0, 4, 6);
		chk("pd", analog_pd, 7'h04);
		wr(4'h0, 4, 7);
		repeat (40) @(posedge clk_sys);
		#1;
		chk("int_clk", clk_int_sel, 1);
		wr(4'h6, 110, '1);
		chk("cal_lock", cal_coeffs, OTP[129:20]);
		wr(4'h0, 4, 8);
		wr(4'h7, 20, 20'h5A5A5);
		chk("trim_test", trim_value, 20'h5A5A5);
		wr(4'h0, 3, 1);
		chk("partial", operating_mode, 8);
		for (int a = 10; a < 12; a++)
		begin
			rd(4'(a), 1);
			chk("unmapped", q[0], 0);
		end
		wr(4'h0, 4, 3);
		conv(1'b0, 16'h8000);
		chk("wake_irq", ready_interrupt_n, 0);
		repeat (10) @(posedge clk_sys);
		#1;
		chk("sleep_pd", analog_pd, 7'h3F);
		rd(4'h4, 18);
		chk("wake_result", q[17:0], 18'h08000);
		ext_clk_present = 1'b0;
		sys_rst = 1'b1;
		repeat (5) @(posedge clk_sys);
		#1;
		sys_rst = 1'b0;
		repeat (180) @(posedge clk_sys);
		#1;
		ce = 1'b0;
		repeat (30) @(posedge clk_sys);
		#1;
		chk("frozen", operating_mode, 0);
		ce = 1'b1;
		repeat (20) @(posedge clk_sys);
		#1;
		chk("wake_default", operating_mode, 3);
		end_sim;
	end
	// Sequence needs well under 40k cycles; a hang ends the run here
	initial
	begin
		#2000000;
		fail_count++;
		end_sim;
	end
endmodule
bind measurement_mode_controller mmc_monitor mon (.clk_sys, .sys_rst, .ser_sel, .conv_res,
	.conv_start, .conv_gen_cfg, .conv_avg_en, .conv_pace, .clk_int_sel, .analog_pd,
	.cal_coeffs, .trim_value, .temp_ref_value, .operating_mode, .ready_interrupt_n);
